//--- bench/wake_source_capture_tb.sv
// testbench for the wake source capture register bank
// assumes a one-cycle wishbone ack and one-cycle event pulses on clk
`timescale 1ns/1ns
`default_nettype none

module wake_source_capture_tb;
  import wake_source_pkg::*;

  // ==========================================================
  // signals and model
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic        wb_ack_o, wake_source_any, energy_efficient_enable;
  logic        suspend_state = 1'b0, resume_started = 1'b0;
  logic [11:0] pin_wake_event = '0;
  logic [8:0]  ev_r = '0;
  logic [4:0]  matching_pattern_index = '0;
  logic [31:0] m_st = '0;
  logic [2:0]  m_ctl = '0;
  logic [31:0] exp_q[$];
  int          error_cnt = 0, n_compared = 0, seed = 32'hf013, i;

  always #5 clk = ~clk;

  // ev_r bit k maps onto status bit 8+k
  wake_source_capture DUT (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .suspend_state(suspend_state),
    .resume_started(resume_started), .pin_wake_event(pin_wake_event), .v6_syn_event(ev_r[8]),
    .v4_syn_event(ev_r[7]), .tx_idle_exit(ev_r[6]), .rx_idle_exit(ev_r[5]),
    .filter_engine_frame(ev_r[4]), .exact_dest_frame(ev_r[3]), .magic_frame(ev_r[2]),
    .broadcast_frame(ev_r[1]), .pattern_frame(ev_r[0]),
    .matching_pattern_index(matching_pattern_index), .wake_source_any(wake_source_any),
    .energy_efficient_enable(energy_efficient_enable));

  // ==========================================================
  // checking and closing
  task chk(input logic [31:0] seen, input logic [31:0] want);
    begin
      n_compared++;
      if (seen !== want)
      begin
        error_cnt++;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
    end
  endtask

  task complete_run();
    begin
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // read data is judged at the ack edge against the oldest note
  always @(posedge clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);

  // ==========================================================
  // bus and event drivers
  task wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50)
      begin
        error_cnt++;
        complete_run();
      end
    end
  endtask

  task rd(input logic [11:0] a);
    begin
      exp_q.push_back(a == STATUS_OFFSET ? m_st : a == CONTROL_OFFSET ? {29'b0, m_ctl} : 32'h0);
      wb(1'b0, a, 4'hf, 32'h0);
    end
  endtask

  task wr(input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] bm;
    begin
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wb(1'b1, a, s, d);
      if (a == STATUS_OFFSET)
        m_st = m_st & ~(d & bm & STATUS_WRITABLE);
      if (a == CONTROL_OFFSET)
      begin
        m_ctl = (m_ctl & ~bm[2:0]) | (d[2:0] & bm[2:0]);
        if (!m_ctl[0])
          m_st[14:13] = 2'b00;
      end
    end
  endtask

  // idle exits count only with the matching enable and the eee enable
  task fire(input logic [11:0] p, input logic [8:0] f, input logic [4:0] ix);
    logic [8:0] g;
    begin
      g = f;
      g[6] = f[6] & m_ctl[0] & m_ctl[1];
      g[5] = f[5] & m_ctl[0] & m_ctl[2];
      @(posedge clk);
      pin_wake_event <= p;
      ev_r <= f;
      matching_pattern_index <= ix;
      @(posedge clk);
      pin_wake_event <= '0;
      ev_r <= '0;
      if (suspend_state === 1'b1 && resume_started === 1'b0)
      begin
        m_st[31:8] = m_st[31:8] | {p, 3'b000, g};
        if (f[0])
          m_st[4:0] = ix;
      end
    end
  endtask

  // ==========================================================
  // scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(STATUS_OFFSET);
    wr(12'h140, 4'hf, 32'hffff_ffff);
    rd(12'h140);
    wr(CONTROL_OFFSET, 4'hf, 32'hffff_ffff);
    rd(CONTROL_OFFSET);
    chk({31'b0, energy_efficient_enable}, {31'b0, m_ctl[0]});
    $display("test 1 finished");
    fire(12'hfff, 9'h1ff, 5'd3);
    rd(STATUS_OFFSET);
    $display("test 2 finished");
    suspend_state <= 1'b1;
    fire(12'h000, 9'h004, 5'd0);
    rd(STATUS_OFFSET);
    chk({31'b0, wake_source_any}, 32'd1);
    for (i = 0; i < 6; i++)
    begin
      fire(12'($random(seed)), 9'($random(seed)) | 9'h001, 5'($random(seed)));
      rd(STATUS_OFFSET);
      wr(STATUS_OFFSET, 4'($random(seed)), 32'($random(seed)));
      rd(STATUS_OFFSET);
    end
    $display("test 3 finished");
    wr(STATUS_OFFSET, 4'hf, 32'hffff_ffff);
    wr(CONTROL_OFFSET, 4'hf, 32'h5);
    fire('0, 9'h060, '0);
    rd(STATUS_OFFSET);
    wr(STATUS_OFFSET, 4'hf, 32'hffff_ffff);
    wr(CONTROL_OFFSET, 4'hf, 32'h3);
    fire('0, 9'h060, '0);
    rd(STATUS_OFFSET);
    wr(CONTROL_OFFSET, 4'hf, 32'h6);
    fire('0, 9'h060, '0);
    rd(STATUS_OFFSET);
    chk({31'b0, energy_efficient_enable}, {31'b0, m_ctl[0]});
    $display("test 4 finished");
    for (i = 0; i < 2; i++)
    begin
      wr(STATUS_OFFSET, 4'hf, 32'hffff_ffff);
      fire(12'h801, 9'h001, i ? 5'd31 : 5'd0);
      repeat (30) @(posedge clk);
      rd(STATUS_OFFSET);
      wr(STATUS_OFFSET, 4'hf, 32'h0);
      rd(STATUS_OFFSET);
    end
    wr(STATUS_OFFSET, 4'b0010, 32'hffff_ffff);
    rd(STATUS_OFFSET);
    $display("test 5 finished");
    resume_started <= 1'b1;
    fire(12'hfff, 9'h1ff, 5'd9);
    rd(STATUS_OFFSET);
    chk({31'b0, wake_source_any}, {31'b0, |m_st[31:8]});
    $display("test 6 finished");
    complete_run();
  end
endmodule

`default_nettype wire

//--- rtl/wake_source_capture.sv
// wake source capture: records which event caused wakeup signalling
// while suspended, behind a classic wishbone slave.
// assumes event inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ns
`default_nettype none

module wake_source_capture
  import wake_source_pkg::*;
(
  input  wire logic                           clk,                  // system clock
  input  wire logic                           reset,                // async reset, active high
  input  wire logic                           wb_cyc_i,             // bus cycle
  input  wire logic                           wb_stb_i,             // strobe
  input  wire logic                           wb_we_i,              // write enable
  input  wire logic [wake_source_pkg::ADDR_W-1:0] wb_adr_i,         // byte address
  input  wire logic [wake_source_pkg::SEL_W-1:0]  wb_sel_i,         // byte lanes
  input  wire logic [wake_source_pkg::DATA_W-1:0] wb_dat_i,         // write data
  output logic [wake_source_pkg::DATA_W-1:0]      wb_dat_o,         // read data
  output logic                                wb_ack_o,             // acknowledge
  input  wire logic                           suspend_state,        // suspend entry complete
  input  wire logic                           resume_started,       // wake-up process under way
  input  wire logic [wake_source_pkg::PIN_COUNT-1:0] pin_wake_event, // per-pin wake pulse
  input  wire logic                           v6_syn_event,         // ipv6 tcp syn received
  input  wire logic                           v4_syn_event,         // ipv4 tcp syn received
  input  wire logic                           tx_idle_exit,         // tx left lpi, delay expired
  input  wire logic                           rx_idle_exit,         // rx left lpi, partner wake
  input  wire logic                           filter_engine_frame,  // frame passed filter engine
  input  wire logic                           exact_dest_frame,     // exact address match
  input  wire logic                           magic_frame,          // magic packet
  input  wire logic                           broadcast_frame,      // broadcast frame
  input  wire logic                           pattern_frame,        // pattern filter match
  input  wire logic [wake_source_pkg::INDEX_W-1:0] matching_pattern_index, // matching filter
  output logic                                wake_source_any,      // any source bit recorded
  output logic                                energy_efficient_enable // control bit to mac
);
  import wake_source_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] control;
    logic [DATA_W-1:0] rdata;
    logic              ack;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  function automatic logic [DATA_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < SEL_W; i++)
    begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  logic              bus_req;
  logic              wr_status;
  logic              wr_control;
  logic              capture;
  logic              eee_en;
  logic              tx_wake_en;
  logic              rx_wake_en;
  logic [DATA_W-1:0] set_vec;
  logic [DATA_W-1:0] clr_vec;

  assign bus_req    = wb_cyc_i & wb_stb_i & ~state_r.ack;
  assign wr_status  = bus_req & wb_we_i & (wb_adr_i == STATUS_OFFSET);
  assign wr_control = bus_req & wb_we_i & (wb_adr_i == CONTROL_OFFSET);
  assign eee_en     = state_r.control[EEE_EN_BIT];
  assign tx_wake_en = state_r.control[TX_WAKE_EN_BIT];
  assign rx_wake_en = state_r.control[RX_WAKE_EN_BIT];

  // capture window
  // only a fully suspended device not yet waking records sources
  assign capture = suspend_state & ~resume_started;

  // ==========================================================
  // next state
  always_comb
  begin
    state_nxt     = state_r;
    state_nxt.ack = bus_req;
    set_vec       = '0;
    // all matching bits
    // sources are or-ed, so one packet may set several bits at once
    if (capture)
    begin
      set_vec[PIN_LSB +: PIN_COUNT] = pin_wake_event;
      set_vec[V6_SYN_BIT]  = v6_syn_event;
      set_vec[V4_SYN_BIT]  = v4_syn_event;
      set_vec[TX_IDLE_BIT] = tx_idle_exit & tx_wake_en & eee_en;
      set_vec[RX_IDLE_BIT] = rx_idle_exit & rx_wake_en & eee_en;
      set_vec[FILTER_BIT]  = filter_engine_frame;
      set_vec[EXACT_BIT]   = exact_dest_frame;
      set_vec[MAGIC_BIT]   = magic_frame;
      set_vec[BCAST_BIT]   = broadcast_frame;
      set_vec[PATTERN_BIT] = pattern_frame;
    end
    clr_vec = wr_status ? (wb_dat_i & lane_mask(wb_sel_i)) : '0;
    // sticky, set wins
    // hardware only sets the source bits, except that the idle bits are forced low while eee is off; a clear in the same cycle loses to the event
    state_nxt.status = (state_r.status & ~clr_vec) | set_vec;
    // filter index
    // index is replaced, not or-ed, so it names the latest match until a status write of ones clears bits 4:0
    if (capture & pattern_frame)
    begin
      state_nxt.status[INDEX_LSB +: INDEX_W] = matching_pattern_index;
    end
    if (!eee_en)
    begin
      state_nxt.status[TX_IDLE_BIT] = 1'b0;
      state_nxt.status[RX_IDLE_BIT] = 1'b0;
    end
    state_nxt.status = state_nxt.status & STATUS_WRITABLE;
    if (wr_control)
    begin
      state_nxt.control = ((state_r.control & ~lane_mask(wb_sel_i))
                           | (wb_dat_i & lane_mask(wb_sel_i))) & CONTROL_WRITABLE;
    end
    // read data; unmapped addresses answer with zero
    state_nxt.rdata = '0;
    if (bus_req & ~wb_we_i)
    begin
      if (wb_adr_i == STATUS_OFFSET)
      begin
        state_nxt.rdata = state_r.status;
      end
      else if (wb_adr_i == CONTROL_OFFSET)
      begin
        state_nxt.rdata = state_r.control;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r.status  <= STATUS_RESET;
      state_r.control <= CONTROL_RESET;
      state_r.rdata   <= '0;
      state_r.ack     <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign wb_dat_o                = state_r.rdata;
  assign wb_ack_o                = state_r.ack;
  assign wake_source_any         = |(state_r.status & ~32'h0000_001f);
  assign energy_efficient_enable = eee_en;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_RESERVED_ZERO: assert property (
    (state_r.status[19:17] == 3'h0) && (state_r.status[7:5] == 3'h0))
    else $error("reserved status bits not zero");

  AST_NO_CAPTURE_OUTSIDE: assert property (
    !capture && !state_r.status[MAGIC_BIT] |=> !state_r.status[MAGIC_BIT])
    else $error("magic bit set outside capture window");

  AST_FROZEN_WHILE_WAKING: assert property (
    resume_started && !wr_status
    |=> state_r.status[31:PIN_LSB] == $past(state_r.status[31:PIN_LSB]))
    else $error("pin bits changed after wake-up began");

  AST_ALL_BITS_SET: assert property (
    capture && magic_frame && broadcast_frame
    |=> state_r.status[MAGIC_BIT] && state_r.status[BCAST_BIT])
    else $error("simultaneous sources not all recorded");

  // bits stay set
  // only the next cycle is promised: a write may clear the bit one cycle later
  AST_STICKY: assert property (
    state_r.status[V4_SYN_BIT] && !wr_status |=> state_r.status[V4_SYN_BIT])
    else $error("ipv4 syn bit cleared without a write");

  AST_PIN_SET: assert property (
    capture && pin_wake_event[0] |=> state_r.status[PIN_LSB])
    else $error("pin 0 wake not recorded");

  AST_TX_GATED: assert property (
    !tx_wake_en && !state_r.status[TX_IDLE_BIT] |=> !state_r.status[TX_IDLE_BIT])
    else $error("tx idle bit set while its wake enable is clear");

  AST_EEE_LOW: assert property (
    !eee_en |=> state_r.status[TX_IDLE_BIT:RX_IDLE_BIT] == 2'b00)
    else $error("eee wake bits not held low");

  AST_INDEX_CAPTURE: assert property (
    capture && pattern_frame
    |=> state_r.status[PATTERN_BIT]
        && state_r.status[INDEX_W-1:0] == $past(matching_pattern_index))
    else $error("filter index not captured");

  AST_ZERO_WRITE_KEEPS: assert property (
    wr_status && wb_sel_i[1] && !wb_dat_i[EXACT_BIT] && state_r.status[EXACT_BIT]
    |=> state_r.status[EXACT_BIT])
    else $error("writing zero cleared a source bit");

  AST_ACK_ONE_CYCLE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  AST_V6_SET: assert property (
    capture && v6_syn_event |=> state_r.status[V6_SYN_BIT])
    else $error("ipv6 syn wake not recorded");

  AST_V4_SET: assert property (
    capture && v4_syn_event |=> state_r.status[V4_SYN_BIT])
    else $error("ipv4 syn wake not recorded");

  AST_TX_SET: assert property (
    capture && tx_idle_exit && tx_wake_en && eee_en |=> state_r.status[TX_IDLE_BIT])
    else $error("tx idle exit wake not recorded");

  AST_RX_SET: assert property (
    capture && rx_idle_exit && rx_wake_en && eee_en |=> state_r.status[RX_IDLE_BIT])
    else $error("rx idle exit wake not recorded");

  AST_RX_GATED: assert property (
    !rx_wake_en && !state_r.status[RX_IDLE_BIT] |=> !state_r.status[RX_IDLE_BIT])
    else $error("rx idle bit set while its wake enable is clear");

  AST_FILTER_SET: assert property (
    capture && filter_engine_frame |=> state_r.status[FILTER_BIT])
    else $error("filter engine frame wake not recorded");

  AST_EXACT_SET: assert property (
    capture && exact_dest_frame |=> state_r.status[EXACT_BIT])
    else $error("exact destination wake not recorded");

  AST_MAGIC_SET: assert property (
    capture && magic_frame |=> state_r.status[MAGIC_BIT])
    else $error("magic packet wake not recorded");

  AST_BCAST_SET: assert property (
    capture && broadcast_frame |=> state_r.status[BCAST_BIT])
    else $error("broadcast wake not recorded");

  AST_PATTERN_SET: assert property (
    capture && pattern_frame |=> state_r.status[PATTERN_BIT])
    else $error("pattern frame wake not recorded");

  AST_INDEX_TOP: assert property (
    capture && pattern_frame && (&matching_pattern_index) |=> (&state_r.status[INDEX_LSB +: INDEX_W]))
    else $error("highest filter index not captured");

  AST_READ_STATUS: assert property (
    bus_req && !wb_we_i && (wb_adr_i == STATUS_OFFSET) |=> wb_ack_o && (wb_dat_o == $past(state_r.status)))
    else $error("status read returned wrong data");

  // whole word frozen while waking
  // eee forcing is excluded by asking the enable to be steady
  AST_FROZEN_ALL: assert property (
    resume_started && !wr_status && $stable(eee_en) |=> (state_r.status == $past(state_r.status)))
    else $error("status changed after wake-up began");

  AST_NO_CAPTURE_PINS: assert property (
    !suspend_state && (state_r.status[PIN_LSB +: PIN_COUNT] == '0) |=> (state_r.status[PIN_LSB +: PIN_COUNT] == '0))
    else $error("pin bit set before suspend entry");

  AST_CLEAR_ONE: assert property (
    wr_status && wb_sel_i[1] && wb_dat_i[EXACT_BIT] && !(capture && exact_dest_frame) |=> !state_r.status[EXACT_BIT])
    else $error("writing one did not clear a source bit");

  // bus: every request answered next cycle
  AST_ACK_AFTER_REQ: assert property (
    bus_req |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");

  // bus: read data zero outside ack
  AST_RDATA_IDLE: assert property (
    !wb_ack_o |-> (wb_dat_o == '0))
    else $error("read data not zero outside ack");

  // bus: unmapped reads return zero
  AST_UNMAPPED_ZERO: assert property (
    bus_req && !wb_we_i && (wb_adr_i != STATUS_OFFSET) && (wb_adr_i != CONTROL_OFFSET) |=> (wb_dat_o == '0))
    else $error("unmapped read returned nonzero data");

endmodule

`default_nettype wire

//--- rtl/wake_source_pkg.sv
// constants for the wake source capture register bank
// assumes a 32-bit classic wishbone slave with byte addresses
package wake_source_pkg;

  // ==========================================================
  // bus geometry
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          SEL_W          = 4;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] STATUS_OFFSET  = 12'h144;
  localparam logic [11:0] CONTROL_OFFSET = 12'h148;

  // ==========================================================
  // wake_source_status field positions
  localparam int          PIN_LSB        = 20;
  localparam int          PIN_COUNT      = 12;
  localparam int          V6_SYN_BIT     = 16;
  localparam int          V4_SYN_BIT     = 15;
  localparam int          TX_IDLE_BIT    = 14;
  localparam int          RX_IDLE_BIT    = 13;
  localparam int          FILTER_BIT     = 12;
  localparam int          EXACT_BIT      = 11;
  localparam int          MAGIC_BIT      = 10;
  localparam int          BCAST_BIT      = 9;
  localparam int          PATTERN_BIT    = 8;
  localparam int          INDEX_LSB      = 0;
  localparam int          INDEX_W        = 5;
  localparam int          FILTER_COUNT   = 32;

  // implemented bits; 19:17 and 7:5 stay zero
  localparam logic [31:0] STATUS_WRITABLE = 32'hfff1_ff1f;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;

  // ==========================================================
  // control word field positions
  localparam int          EEE_EN_BIT     = 0;
  localparam int          TX_WAKE_EN_BIT = 1;
  localparam int          RX_WAKE_EN_BIT = 2;
  localparam logic [31:0] CONTROL_WRITABLE = 32'h0000_0007;
  localparam logic [31:0] CONTROL_RESET    = 32'h0000_0000;

endpackage
